/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wdrul_pkg::*;
  localparam int T = 4;  // short tick keeps every time-out within a few thousand cycles
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, refresh, irq, sreq, pe;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [15:0] seed = 16'hDA24;  // fixed start 55844
  logic [7:0]  m, l;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n, rv;

  always #20 pclk = ~pclk;

  wdrul_top #(.TICK_CYCLES(T)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .watchdog_refresh_instruction(refresh), .irq,
    .system_reset_req(sreq));
  wdrul_core_model core (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .refresh);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // byte address of a register index
  function automatic logic [31:0] ba(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction : ba
  // latest edge a time-out may show for reload value v
  function automatic int late(input int v);
    return (v + 2) * T + 6;
  endfunction : late

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic check_win(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED at %0t: event after %0d cycles, want %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_win
  // one bus access; a missing answer ends the run
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    bit ok;
    core.xfer(w, a, d, r, pe, ok);
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      give_verdict();
    end
  endtask : xfer
  task automatic unlock();
    xfer(1'b1, ba(IDX_UNLOCK), {24'h0, UNLOCK_FIRST});
    xfer(1'b1, ba(IDX_UNLOCK), {24'h0, UNLOCK_SECOND});
  endtask : unlock
  // refresh, then time the next time-out; edges right after the load are skipped
  task automatic wait_event(input int lo, input int hi, input logic use_irq);
    core.pulse();
    for (n = 1; n < 3 * hi; n++) begin
      @(posedge pclk);
      if (n > 3 && (use_irq ? irq : sreq) === 1'b1) break;
    end
    check_win(n, lo, hi);
    if (n >= 3 * hi) give_verdict();
  endtask : wait_event

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // stopped counter reads all ones, unlock port keeps nothing
    xfer(1'b0, ba(IDX_UPPER), 32'h0);
    check(r, 32'hFF);
    unlock();
    xfer(1'b0, ba(IDX_UNLOCK), 32'h0);
    check(r, 32'h0);
    xfer(1'b0, ba(IDX_CTRL), 32'h0);
    check(r, 32'h1 << CTRL_UNLOCKED);
    seed = lfsr(seed);
    // out-of-order byte relocks; locked upper write is dropped
    xfer(1'b1, ba(IDX_MIDDLE), {24'h0, seed[7:0]});
    xfer(1'b0, ba(IDX_CTRL), 32'h0);
    check(r, 32'h0);
    xfer(1'b1, ba(IDX_UPPER), {24'h0, seed[15:8]});
    xfer(1'b0, 32'h0000_4000, 32'h0);
    check({31'h0, pe}, 32'h1);
    rv = {RST_UPPER, RST_MIDDLE, RST_LOW};
    wait_event(rv * T, late(rv), 1'b0);
    // random legal reload, never below four
    seed = lfsr(seed);
    m = 8'h01 + {6'h0, seed[1:0] % 2'h3};
    l = 8'h80 | seed[15:8];
    unlock();
    xfer(1'b1, ba(IDX_UPPER), 32'h0);
    xfer(1'b1, ba(IDX_MIDDLE), {24'h0, m});
    xfer(1'b1, ba(IDX_LOW), {24'h0, l});
    xfer(1'b0, ba(IDX_CTRL), 32'h0);
    check(r, 32'h0);
    xfer(1'b1, ba(IDX_MIDDLE), {24'h0, ~m});
    xfer(1'b1, ba(IDX_LOW), 32'h0);
    core.pulse();
    xfer(1'b0, ba(IDX_MIDDLE), 32'h0);
    check(r, {24'h0, m});
    rv = {16'h0, m, l};
    wait_event(rv * T, late(rv), 1'b0);
    check({31'h0, irq}, 32'h0);
    xfer(1'b0, ba(IDX_STATUS), 32'h0);
    check(r, 32'h1 << ST_RELOAD);
    // refresh at count two or below cannot save it
    unlock();
    xfer(1'b1, ba(IDX_UPPER), 32'h0);
    xfer(1'b1, ba(IDX_MIDDLE), 32'h0);
    xfer(1'b1, ba(IDX_LOW), 32'h8);
    core.pulse();
    for (rv = 0; rv < 40; rv++) begin
      xfer(1'b0, ba(IDX_LOW), 32'h0);
      if (r[7:0] <= CNT_NO_REFRESH[7:0]) break;
    end
    check_win(rv, 0, 39);
    wait_event(1, 3 * T + 6, 1'b0);
    // larger reload, taken at the next reset time-out, so the coming
    // refresh never lands at count two or below
    unlock();
    xfer(1'b1, ba(IDX_UPPER), 32'h0);
    xfer(1'b1, ba(IDX_MIDDLE), 32'h0);
    xfer(1'b1, ba(IDX_LOW), 32'h40);
    repeat (3) @(posedge pclk);
    for (n = 0; n < 100 && sreq !== 1'b1; n++) @(posedge pclk);
    check_win(n, 0, 99);
    if (n >= 100) give_verdict();
    // interrupt response: raise, read-clear, wrap
    xfer(1'b1, ba(IDX_CTRL), 32'h3);
    xfer(1'b1, ba(IDX_MASK), 32'h1 << ST_TIMEOUT);
    xfer(1'b0, ba(IDX_STATUS), 32'h0);
    wait_event(64 * T, late(64), 1'b1);
    xfer(1'b0, ba(IDX_UNLOCK), 32'h0);
    check(r, 32'h1 << RSTAT_WDT);
    xfer(1'b0, ba(IDX_UPPER), 32'h0);
    check(r, {24'h0, CNT_WRAP[23:16]});
    xfer(1'b0, ba(IDX_STATUS), 32'h0);
    check(r, 32'h1 << ST_TIMEOUT);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

/* wdrul_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the watchdog register front end
module wdrul_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        watchdog_refresh_instruction,
  input wire logic        irq,
  input wire logic        system_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a read answer at this edge
  wire logic rd_done = pready && !pwrite;

  AST_WAIT_STATE: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (pready && paddr[31:14] != 18'h0 |-> pslverr)
    else $error("unmapped access not refused");
  AST_UNLOCK_WO: assert property (rd_done && paddr == 32'h3FC0 |-> prdata[6:0] == 7'h0)
    else $error("unlock port read returns written bits");
  AST_BYTE_READ: assert property (rd_done && paddr inside {32'h3FC4, 32'h3FC8, 32'h3FCC}
    |-> prdata[31:8] == 24'h0 && !pslverr)
    else $error("reload byte read malformed");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  AST_RESET_PULSE: assert property ($rose(system_reset_req) |=> !system_reset_req)
    else $error("reset request wider than one cycle");

  // main scenarios seen
  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (system_reset_req);
endmodule : wdrul_assertions

bind wdrul_top wdrul_assertions u_ast (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .watchdog_refresh_instruction, .irq, .system_reset_req);
`default_nettype wire

/* wdrul_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// processor core: apb master plus refresh instruction pulses
module wdrul_core_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  output logic             refresh
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, refresh} = 4'h0;
    paddr  = 32'h0;
    pwdata = 32'h0;
  end

  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output bit ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // bounded wait; caller treats a miss as a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r  = prdata;
    e  = pslverr;
    ok = (pready === 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // refresh instruction is a single-cycle pulse
  task automatic pulse();
    @(posedge pclk);
    refresh <= 1'b1;
    @(posedge pclk);
    refresh <= 1'b0;
  endtask : pulse
endmodule : wdrul_core_model
`default_nettype wire

/* wdrul_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module wdrul_counter
  import wdrul_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          tick,        // one watchdog oscillator period
  input  wire logic          running,     // counter enabled
  input  wire logic          load,        // copy reload value in
  input  wire wdrul_reload_t reload,
  input  wire logic          resp_irq,    // time-out response option
  output logic      [23:0]   count,
  output logic               timeout      // one-cycle pulse
);

  // down counter; load has priority over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= CNT_WRAP;
    end else if (load) begin
      count <= reload;
    end else if (running && tick) begin
      if (count == CNT_ZERO) begin
        // interrupt response keeps running from the top, not the reload
        count <= resp_irq ? CNT_WRAP : reload;
      end else begin
        count <= count - 24'h000001;
      end
    end
  end

  // time-out fires on the tick that leaves zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout <= 1'b0;
    end else begin
      timeout <= running && tick && !load && (count == CNT_ZERO);
    end
  end

endmodule : wdrul_counter
`default_nettype wire

/* wdrul_pkg.sv */
`default_nettype none
package wdrul_pkg;

  // register indices; byte address on apb is four times the index
  localparam logic [11:0] IDX_UNLOCK  = 12'hFF0;  // write: unlock port, read: reset status
  localparam logic [11:0] IDX_UPPER   = 12'hFF1;  // reload bits 23:16
  localparam logic [11:0] IDX_MIDDLE  = 12'hFF2;  // reload bits 15:8
  localparam logic [11:0] IDX_LOW     = 12'hFF3;  // reload bits 7:0
  localparam logic [11:0] IDX_CTRL    = 12'hFF4;  // enable, response option, lock view
  localparam logic [11:0] IDX_STATUS  = 12'hFF5;  // sticky events, cleared by read
  localparam logic [11:0] IDX_MASK    = 12'hFF6;  // interrupt mask, same layout

  // unlock code bytes
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // reload reset values
  localparam logic [7:0] RST_UPPER  = 8'h00;
  localparam logic [7:0] RST_MIDDLE = 8'h04;
  localparam logic [7:0] RST_LOW    = 8'h00;

  // counter thresholds
  localparam logic [23:0] CNT_ZERO       = 24'h000000;
  localparam logic [23:0] CNT_NO_REFRESH = 24'h000002;
  localparam logic [23:0] CNT_WRAP       = 24'hFFFFFF;

  // control register fields
  localparam int CTRL_ENABLE   = 0;  // 1 starts the counter
  localparam int CTRL_RESP_IRQ = 1;  // 1 interrupt, 0 system reset
  localparam int CTRL_UNLOCKED = 4;  // read only: reload bytes writable

  // status and mask fields
  localparam int ST_TIMEOUT = 0;  // counter reached zero under interrupt response
  localparam int ST_RELOAD  = 1;  // reload sequence completed
  localparam int ST_WIDTH   = 2;

  // reset status field shown at the unlock address
  localparam int RSTAT_WDT = 7;

  // timing: bus clock and watchdog oscillator rate
  localparam int CLK_HZ     = 25_000_000;
  localparam int OSC_HZ     = 10_000;
  localparam int TICK_DIV   = CLK_HZ / OSC_HZ;  // bus cycles per watchdog tick

  // reload value carried as three bytes
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] middle;
    logic [7:0] low;
  } wdrul_reload_t;

  // lock sequencer
  typedef enum logic [2:0] {
    LK_LOCKED,
    LK_GOT_FIRST,
    LK_WANT_UPPER,
    LK_WANT_MIDDLE,
    LK_WANT_LOW
  } wdrul_lock_t;

endpackage : wdrul_pkg
`default_nettype wire

/* wdrul_top.sv */
`timescale 1ns/100ps
`default_nettype none
module wdrul_top
  import wdrul_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV  // bus cycles per watchdog tick
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        watchdog_refresh_instruction,  // one-cycle pulse from core
  output logic             irq,                           // level interrupt
  output logic             system_reset_req                // one-cycle pulse
);

  // divider width; one spare value so the terminal count always fits
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // register state
  // software-visible flops live here; the counter module stays a plain
  // datapath so its timing can be checked without any bus in the way
  wdrul_reload_t reload;        // reload bytes
  wdrul_lock_t   lock_state;    // unlock sequencer
  logic          ctrl_enable;   // software enable
  logic          timeout_response_option; // 1 interrupt, 0 reset
  logic [ST_WIDTH-1:0] status;  // sticky events
  logic [ST_WIDTH-1:0] mask;    // interrupt enables
  logic          reset_flag;    // reset status: watchdog timed out
  logic          running;       // counter active
  logic [TW-1:0] prescale;      // oscillator period divider
  logic          tick;          // one watchdog tick

  // counter view
  // count is read back live through the reload byte addresses, so the
  // bytes software reads are the current count, not the reload bytes it wrote
  logic [23:0]   count;
  logic          timeout;
  logic          load;

  // bus decode
  // all strobes derive from one index so that adding a register means
  // one compare here and one arm in the read mux
  logic [11:0]   idx;           // register index
  logic          in_map;        // address hits a register
  logic          access;        // access cycle completing this edge
  logic          wr_done;       // write takes effect this edge
  logic          rd_done;       // read data captured this edge
  logic [31:0]   rdata;         // combinational read mux
  logic          wr_unlock;
  logic          wr_upper;
  logic          wr_middle;
  logic          wr_low;
  logic          reload_done;   // sequence finished with low byte

  // word aligned index; low two bits ignored
  // anything above the index field must be zero, otherwise the access is
  // refused with pslverr rather than aliased onto the register block
  assign idx     = paddr[13:2];
  assign in_map  = (paddr[31:14] == 18'h00000) &&
                   (idx >= IDX_UNLOCK) && (idx <= IDX_MASK);
  assign access  = psel && penable && pready;
  assign wr_done = access && pwrite && in_map;
  // read side effects act where prdata is captured: a flag set between
  // capture and answer would otherwise be cleared without being reported
  assign rd_done = psel && penable && !pready && !pwrite && in_map;

  // per-register write strobes
  // each strobe is already qualified by the access edge, so every
  // consumer below can use it without looking at the handshake again
  assign wr_unlock = wr_done && (idx == IDX_UNLOCK);
  assign wr_upper  = wr_done && (idx == IDX_UPPER);
  assign wr_middle = wr_done && (idx == IDX_MIDDLE);
  assign wr_low    = wr_done && (idx == IDX_LOW);
  assign reload_done = wr_low && (lock_state == LK_WANT_LOW);

  // apb handshake: one wait state so prdata can come from a flop
  // the cost is one extra cycle per access; in exchange every bus
  // output comes straight from a flop and no read path reaches a pin
  // through logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;  // answer on second access cycle
    end else begin
      pready <= 1'b0;
    end
  end

  // read mux; the unlock port never reflects its own write data
  // unused bits read as zero; the reload addresses show the live count,
  // which software must not mistake for the reload value it stored
  always_comb begin
    rdata = 32'h00000000;
    unique case (idx)
      IDX_UNLOCK: rdata[RSTAT_WDT] = reset_flag;
      IDX_UPPER:  rdata[7:0] = count[23:16];
      IDX_MIDDLE: rdata[7:0] = count[15:8];
      IDX_LOW:    rdata[7:0] = count[7:0];
      IDX_CTRL: begin
        rdata[CTRL_ENABLE]   = ctrl_enable;
        rdata[CTRL_RESP_IRQ] = timeout_response_option;
        rdata[CTRL_UNLOCKED] = (lock_state == LK_WANT_UPPER) ||
                               (lock_state == LK_WANT_MIDDLE) ||
                               (lock_state == LK_WANT_LOW);
      end
      IDX_STATUS: rdata[ST_WIDTH-1:0] = status;
      IDX_MASK:   rdata[ST_WIDTH-1:0] = mask;
      default:    rdata = 32'h00000000;
    endcase
  end

  // read data and error captured as the answer is raised
  // prdata returns to zero outside the answer cycle, so a stale word
  // can never be mistaken for a fresh read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= (!pwrite && in_map) ? rdata : 32'h00000000;
      pslverr <= !in_map;  // unmapped address
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // lock sequencer; any other write breaks the sequence
  // reads leave it alone, so software may poll status mid-sequence;
  // writes to unmapped addresses never reach it either, since they
  // are refused before any strobe is raised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_state <= LK_LOCKED;
    end else if (wr_done) begin
      unique case (lock_state)
        LK_LOCKED: begin
          if (wr_unlock && pwdata[7:0] == UNLOCK_FIRST) begin
            lock_state <= LK_GOT_FIRST;
          end
        end
        LK_GOT_FIRST: begin
          if (wr_unlock && pwdata[7:0] == UNLOCK_SECOND) begin
            lock_state <= LK_WANT_UPPER;
          end else if (wr_unlock && pwdata[7:0] == UNLOCK_FIRST) begin
            lock_state <= LK_GOT_FIRST;  // repeated first byte restarts
          end else begin
            lock_state <= LK_LOCKED;
          end
        end
        LK_WANT_UPPER: begin
          lock_state <= wr_upper ? LK_WANT_MIDDLE : LK_LOCKED;
        end
        LK_WANT_MIDDLE: begin
          lock_state <= wr_middle ? LK_WANT_LOW : LK_LOCKED;
        end
        LK_WANT_LOW: begin
          lock_state <= LK_LOCKED;
        end
        default: begin
          lock_state <= LK_LOCKED;  // unused codes fall back to locked
        end
      endcase
    end
  end

  // reload bytes; writes land only in the sequence position they belong to
  // a byte written out of turn is dropped, not stored for later, so a
  // stray write can never change the time-out period on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload.upper  <= RST_UPPER;
      reload.middle <= RST_MIDDLE;
      reload.low    <= RST_LOW;
    end else begin
      if (wr_upper && lock_state == LK_WANT_UPPER) begin
        reload.upper <= pwdata[7:0];
      end
      if (wr_middle && lock_state == LK_WANT_MIDDLE) begin
        reload.middle <= pwdata[7:0];
      end
      if (reload_done) begin
        reload.low <= pwdata[7:0];
      end
    end
  end

  // control register; the unlock port has no stored bits to disturb
  // kept at its own address so that unlock writes cannot reach it;
  // the lock view bit is read only and has no flop here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable             <= 1'b0;
      timeout_response_option <= 1'b0;
    end else if (wr_done && idx == IDX_CTRL) begin
      ctrl_enable             <= pwdata[CTRL_ENABLE];
      timeout_response_option <= pwdata[CTRL_RESP_IRQ];
    end
  end  // wr_unlock reaches only the sequencer

  // mask register
  // same layout as status; masking hides an event from irq only, the
  // sticky bit is still set and readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (wr_done && idx == IDX_MASK) begin
      mask <= pwdata[ST_WIDTH-1:0];
    end
  end

  // sticky events; a new event in the clearing cycle survives the clear
  // the clear acts on the edge that captures the read data, so the
  // word software sees and the bits cleared are one snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      for (int i = 0; i < ST_WIDTH; i++) begin
        if (rd_done && idx == IDX_STATUS) begin
          status[i] <= 1'b0;
        end
      end
      if (timeout && timeout_response_option) begin
        status[ST_TIMEOUT] <= 1'b1;
      end
      if (reload_done) begin
        status[ST_RELOAD] <= 1'b1;
      end
    end
  end

  // reset status flag, cleared by reading the shared unlock address
  // set on every time-out, whatever the response, so software can tell
  // after a restart that the watchdog was the cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_flag <= 1'b0;
    end else if (timeout) begin
      reset_flag <= 1'b1;  // set beats the read clear
    end else if (rd_done && idx == IDX_UNLOCK) begin
      reset_flag <= 1'b0;
    end
  end

  // interrupt output from a flop, one cycle after the cause
  // a level, not a pulse: it stays high until software reads status
  // or clears the mask bit, so a late handler still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // reset response drives a one-cycle request to the system
  // the reset itself is applied elsewhere; this block only asks for it,
  // and keeps counting from the reload value in case nobody listens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= timeout && !timeout_response_option;
    end
  end

  // run flag: software enable or the first refresh instruction starts it
  // there is no way to stop it again short of reset, so a runaway
  // program cannot switch the watchdog off; the price is that a test
  // harness must reset the block to stop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (ctrl_enable || watchdog_refresh_instruction) begin
      running <= 1'b1;  // once on, it stays on until reset
    end
  end

  // first start and refresh both load; late refreshes are dropped
  // so a time-out at most three ticks away cannot be dodged; a reload
  // below four would leave almost no window for a refresh at all,
  // which is why software must keep it at four or more
  assign load = (!running && (ctrl_enable || watchdog_refresh_instruction)) ||
                (running && watchdog_refresh_instruction &&
                 (count > CNT_NO_REFRESH));

  // divider stands in for the slow watchdog oscillator
  // held at zero while stopped so the first tick after a start comes a
  // full period later; the divider keeps its phase across a refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
      tick     <= 1'b0;
    end else if (!running || prescale == TW'(TICK_CYCLES - 1)) begin
      prescale <= '0;
      tick     <= running;
    end else begin
      prescale <= prescale + TW'(1);
      tick     <= 1'b0;
    end
  end

  // the down counter itself; reload bytes concatenate upper first
  // load and tick meet inside; load wins, so a refresh on a tick edge
  // simply restarts the count from the full reload value
  wdrul_counter u_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick),
    .running  (running),
    .load     (load),
    .reload   (reload),
    .resp_irq (timeout_response_option),
    .count    (count),
    .timeout  (timeout)
  );

endmodule : wdrul_top
`default_nettype wire
